// ===== rtl/i2c_map_port_regs.svh
// register offsets, field positions, reset values and address constants of the serial map port
`ifndef I2C_MAP_PORT_REGS_SVH
`define I2C_MAP_PORT_REGS_SVH

// main map slave address with the select bit at zero, 7-bit form of 0x40
`define MAIN_ADDR7_BASE 7'h20
// position of the pin-driven bit within the 7-bit address (byte bit 1)
`define MAIN_ADDR7_SEL_BIT 0

`define SUBMAP_SELECT_OFFSET 8'h0e
`define SUBMAP_SELECT_RESET 8'h00
`define SUBMAP_FIELD_HI 6
`define SUBMAP_FIELD_LO 5

`define POSTPROC_ADDR_OFFSET 8'hfd
`define POSTPROC_ADDR_RESET 8'h00
`define POSTPROC_FIELD_HI 7
`define POSTPROC_FIELD_LO 1

// highest valid subaddress in every map
`define TOP_SUBADDR 8'hfe

// bits per byte on the wire and the count that marks the acknowledge pulse
`define BYTE_BITS 4'h8
`define ACK_PULSE 4'h9

`endif

// ===== rtl/i2c_map_port_pkg.sv
// types shared by the serial map port design
package i2c_map_port_pkg;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_SUB      = 4'h2,
    ST_SUB_ACK  = 4'h6,
    ST_WDATA    = 4'h7,
    ST_WACK     = 4'h5,
    ST_RDATA    = 4'hb,
    ST_RACK     = 4'hf
  } port_state_t;

  typedef enum logic [1:0] {
    MAP_USER   = 2'h0,
    MAP_INTVBI = 2'h1,
    MAP_USER2  = 2'h2,
    MAP_VPP    = 2'h3
  } map_sel_t;

endpackage

// ===== rtl/pin_sync.sv
// two-flop synchroniser for one pin with edge detection on the synchronised copy
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pin side
  input wire logic pin,
  // synchronised side
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // lines idle high, so reset to one to avoid a false edge after release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule

// ===== rtl/i2c_register_map_port.sv
// two-wire serial slave port giving access to the main sub maps and the postprocessor map
`timescale 1ns/1ps
`include "i2c_map_port_regs.svh"
module i2c_register_map_port (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial link pins
  input wire logic serial_clock_pin,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  // strap
  input wire logic addr_select_pin,
  // configuration seen by the rest of the decoder
  output logic [7:0] submap_select,
  output logic [7:0] postproc_map_address
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  logic scl;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic sda_rise;
  logic sda_fall;
  logic sel_level;

  pin_sync u_scl_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_sync_q),
    .pin(serial_clock_pin),
    .level(scl),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  pin_sync u_sda_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_sync_q),
    .pin(serial_data_in),
    .level(sda),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  pin_sync u_sel_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_sync_q),
    .pin(addr_select_pin),
    .level(sel_level),
    .rise(),
    .fall()
  );

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  // one byte array per map; 0x0e (all maps but the postprocessor map) and 0xfd (user map only) live in flops outside it
  logic [7:0] map_mem [0:3][0:255];
  logic [7:0] submap_q;
  logic [7:0] submap_d;
  logic [7:0] postproc_q;
  logic [7:0] postproc_d;
  logic mem_we;

  ////////////////////////////////////////////////////////////////////////////
  // protocol state

  i2c_map_port_pkg::port_state_t state_q;
  i2c_map_port_pkg::port_state_t state_d;
  i2c_map_port_pkg::map_sel_t map_q;
  i2c_map_port_pkg::map_sel_t map_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic past_q;
  logic past_d;
  logic rw_q;
  logic rw_d;
  logic nack_q;
  logic nack_d;
  logic oe_q;
  logic oe_d;

  logic start_cond;
  logic stop_cond;
  logic [6:0] main_addr7;
  logic main_hit;
  logic vpp_hit;
  logic [7:0] rd_byte;
  logic [7:0] next_ptr;

  assign start_cond = sda_fall & scl;
  assign stop_cond = sda_rise & scl;

  always_comb begin
    main_addr7 = `MAIN_ADDR7_BASE;
    main_addr7[`MAIN_ADDR7_SEL_BIT] = sel_level;
  end

  assign main_hit = shift_q[7:1] == main_addr7;
  // a zero postprocessor address leaves that map unreachable
  assign vpp_hit = (postproc_q[`POSTPROC_FIELD_HI:`POSTPROC_FIELD_LO] != 7'h00) &&
                   (shift_q[7:1] == postproc_q[`POSTPROC_FIELD_HI:`POSTPROC_FIELD_LO]);

  // read data for the current pointer, shared registers overlay the arrays
  always_comb begin
    rd_byte = map_mem[map_q][ptr_q];
    if (map_q != i2c_map_port_pkg::MAP_VPP && ptr_q == `SUBMAP_SELECT_OFFSET) begin
      rd_byte = submap_q;
    end else if (map_q == i2c_map_port_pkg::MAP_USER && ptr_q == `POSTPROC_ADDR_OFFSET) begin
      rd_byte = postproc_q;
    end
  end

  // pointer saturates at the top so long reads repeat the last register
  assign next_ptr = (ptr_q == `TOP_SUBADDR) ? ptr_q : ptr_q + 8'h01;

  always_comb begin
    state_d = state_q;
    map_d = map_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    past_d = past_q;
    rw_d = rw_q;
    nack_d = nack_q;
    oe_d = oe_q;
    submap_d = submap_q;
    postproc_d = postproc_q;
    mem_we = 1'b0;
    if (start_cond) begin
      state_d = i2c_map_port_pkg::ST_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop_cond) begin
      state_d = i2c_map_port_pkg::ST_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (state_q)
        i2c_map_port_pkg::ST_IDLE: begin
          oe_d = 1'b0;
        end
        i2c_map_port_pkg::ST_ADDR, i2c_map_port_pkg::ST_SUB, i2c_map_port_pkg::ST_WDATA: begin
          if (scl_rise && cnt_q < `BYTE_BITS) begin
            shift_d = {shift_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `BYTE_BITS) begin
            cnt_d = 4'h0;
            if (state_q == i2c_map_port_pkg::ST_ADDR) begin
              rw_d = shift_q[0];
              if (vpp_hit) begin
                map_d = i2c_map_port_pkg::MAP_VPP;
              end else begin
                // reserved select value falls back to the user sub map
                map_d = (submap_q[`SUBMAP_FIELD_HI:`SUBMAP_FIELD_LO] == 2'h3) ? i2c_map_port_pkg::MAP_USER :
                        i2c_map_port_pkg::map_sel_t'(submap_q[`SUBMAP_FIELD_HI:`SUBMAP_FIELD_LO]);
              end
              if (main_hit || vpp_hit) begin
                state_d = i2c_map_port_pkg::ST_ADDR_ACK;
                oe_d = 1'b1;
              end else begin
                state_d = i2c_map_port_pkg::ST_IDLE;
              end
            end else if (state_q == i2c_map_port_pkg::ST_SUB) begin
              if (shift_q <= `TOP_SUBADDR) begin
                ptr_d = shift_q;
                past_d = 1'b0;
                state_d = i2c_map_port_pkg::ST_SUB_ACK;
                oe_d = 1'b1;
              end else begin
                state_d = i2c_map_port_pkg::ST_IDLE;
              end
            end else if (past_q) begin
              state_d = i2c_map_port_pkg::ST_IDLE;
            end else begin
              if (map_q != i2c_map_port_pkg::MAP_VPP && ptr_q == `SUBMAP_SELECT_OFFSET) begin
                submap_d = shift_q;
              end else if (map_q == i2c_map_port_pkg::MAP_USER && ptr_q == `POSTPROC_ADDR_OFFSET) begin
                postproc_d = shift_q;
              end else begin
                mem_we = 1'b1;
              end
              past_d = ptr_q == `TOP_SUBADDR;
              ptr_d = next_ptr;
              state_d = i2c_map_port_pkg::ST_WACK;
              oe_d = 1'b1;
            end
          end
        end
        i2c_map_port_pkg::ST_ADDR_ACK, i2c_map_port_pkg::ST_SUB_ACK, i2c_map_port_pkg::ST_WACK: begin
          if (scl_rise) begin
            cnt_d = `ACK_PULSE;
          end else if (scl_fall && cnt_q == `ACK_PULSE) begin
            cnt_d = 4'h0;
            if (state_q == i2c_map_port_pkg::ST_ADDR_ACK && rw_q) begin
              shift_d = rd_byte;
              oe_d = ~rd_byte[7];
              state_d = i2c_map_port_pkg::ST_RDATA;
            end else begin
              oe_d = 1'b0;
              state_d = (state_q == i2c_map_port_pkg::ST_ADDR_ACK) ? i2c_map_port_pkg::ST_SUB :
                        i2c_map_port_pkg::ST_WDATA;
            end
          end
        end
        i2c_map_port_pkg::ST_RDATA: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == `BYTE_BITS) begin
              cnt_d = 4'h0;
              oe_d = 1'b0;
              ptr_d = next_ptr;
              state_d = i2c_map_port_pkg::ST_RACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              oe_d = ~shift_q[6];
            end
          end
        end
        i2c_map_port_pkg::ST_RACK: begin
          if (scl_rise) begin
            nack_d = sda;
            cnt_d = `ACK_PULSE;
          end else if (scl_fall && cnt_q == `ACK_PULSE) begin
            cnt_d = 4'h0;
            if (nack_q) begin
              state_d = i2c_map_port_pkg::ST_IDLE;
            end else begin
              shift_d = rd_byte;
              oe_d = ~rd_byte[7];
              state_d = i2c_map_port_pkg::ST_RDATA;
            end
          end
        end
        default: begin
          state_d = i2c_map_port_pkg::ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= i2c_map_port_pkg::ST_IDLE;
      map_q <= i2c_map_port_pkg::MAP_USER;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      past_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      oe_q <= 1'b0;
      submap_q <= `SUBMAP_SELECT_RESET;
      postproc_q <= `POSTPROC_ADDR_RESET;
    end else begin
      state_q <= state_d;
      map_q <= map_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      past_q <= past_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      oe_q <= oe_d;
      submap_q <= submap_d;
      postproc_q <= postproc_d;
    end
  end

  // array has no reset; contents are undefined until written
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      map_mem[map_q][ptr_q] <= shift_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic sda_low_q;

  // open-drain: only ever drives low
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sda_low_q <= 1'b0;
    end else begin
      sda_low_q <= 1'b0;
    end
  end

  assign serial_data_out = sda_low_q;
  assign serial_data_oe = oe_q;
  assign submap_select = submap_q;
  assign postproc_map_address = postproc_q;

endmodule

// ===== sim/i2c_map_port_checker.sv
// concurrent checks on the pins of the two-wire map port
`timescale 1ns/1ps
module i2c_map_port_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link and strap
  input wire logic serial_clock_pin,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic addr_select_pin,
  // registers
  input wire logic [7:0] submap_select,
  input wire logic [7:0] postproc_map_address
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence start_s;
    serial_clock_pin && $fell(serial_data_in);
  endsequence
  sequence stop_s;
    serial_clock_pin && $rose(serial_data_in);
  endsequence
  sequence stored_s;
    !serial_clock_pin ##[0:3] serial_data_oe;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  drive_low_a: assert property (serial_data_oe |-> serial_data_out == 1'b0)
    else $error("data pin driven high");
  reset_zero_a: assert property ($rose(rst_n) |-> submap_select == 8'h00 && postproc_map_address == 8'h00)
    else $error("register not zero after reset");
  start_quiet_a: assert property (start_s |-> !serial_data_oe [*8])
    else $error("data driven right after start");
  stop_quiet_a: assert property (stop_s |=> !serial_data_oe [*8])
    else $error("data driven after stop");
  // a change while the clock is high would look like a start or stop to others
  oe_clock_low_a: assert property ($changed(serial_data_oe) |-> !serial_clock_pin && !$past(serial_clock_pin))
    else $error("data drive changed with clock high");
  select_ack_a: assert property ($changed(submap_select) |-> stored_s)
    else $error("select stored without acknowledge");
  pp_ack_a: assert property ($changed(postproc_map_address) |-> stored_s)
    else $error("map address stored without acknowledge");
  select_apart_a: assert property ($changed(submap_select) |-> $stable(postproc_map_address))
    else $error("two registers written by one byte");
endmodule

// ===== sim/serial_master_model.sv
// serial bus master model driving clock and data of the two-wire link
`timescale 1ns/1ps
module serial_master_model (
  // clock
  input wire logic clk_sys,
  // link
  output logic scl,
  output logic sda,
  input wire logic sda_wire
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // a quarter of the 320 ns link period
  task automatic q();
    repeat (2) @(posedge clk_sys);
  endtask
  // data rises while clock is low so this also serves as repeated start
  task automatic start();
    q();
    sda <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda <= 1'b0;
    q();
    scl <= 1'b0;
  endtask
  task automatic stop();
    q();
    sda <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda <= 1'b1;
    q();
  endtask
  // data changes only while the clock is low; wire sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    q();
    sda <= b;
    q();
    scl <= 1'b1;
    q();
    r = sda_wire;
    q();
    scl <= 1'b0;
  endtask
  // eight bits msb first, ninth at n9: one releases, zero acknowledges
  task automatic xfer(input logic [7:0] d, input logic n9, output logic [7:0] rd, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      rd[i] = r;
    end
    bit_x(n9, r);
    ack = ~r;
  endtask
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the two-wire map port
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, rst_n, addr_select_pin, serial_data_out, serial_data_oe, scl, sda, sda_wire;
  logic [7:0] submap_select, postproc_map_address;
  logic [7:0] wb[4];
  logic [7:0] rb[4];
  int num_errors, num_checks, na;
  // open drain with pull-up
  assign sda_wire = sda & ~serial_data_oe;
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  i2c_register_map_port i2c_register_map_port_i (.clk_sys(clk_sys), .rst_n(rst_n), .serial_clock_pin(scl),
    .serial_data_in(sda_wire), .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .addr_select_pin(addr_select_pin), .submap_select(submap_select), .postproc_map_address(postproc_map_address));
  serial_master_model serial_master_model_i (.clk_sys(clk_sys), .scl(scl), .sda(sda), .sda_wire(sda_wire));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t want %h got %h", $time, e, g);
    end
  endtask
  // write n bytes of wb from s; na counts acks up to the first refusal
  task automatic wr(input logic [7:0] a, input logic [7:0] s, input int n);
    logic [7:0] x;
    logic k;
    na = 0;
    serial_master_model_i.start();
    serial_master_model_i.xfer(a, 1'b1, x, k);
    for (int i = -1; i < n && k; i++) begin
      na++;
      serial_master_model_i.xfer(i < 0 ? s : wb[i], 1'b1, x, k);
    end
    if (k) na++;
    serial_master_model_i.stop();
  endtask
  // set the pointer, then read n bytes, refusing the last
  task automatic rd(input logic [7:0] a, input logic [7:0] s, input int n);
    logic k;
    wr(a, s, 0);
    chk(8'h02, 8'(na));
    serial_master_model_i.start();
    serial_master_model_i.xfer(a | 8'h01, 1'b1, rb[0], k);
    for (int i = 0; i < n; i++)
      serial_master_model_i.xfer(8'hff, i == n - 1, rb[i], k);
    serial_master_model_i.stop();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(8'h00, submap_select);
    chk(8'h00, postproc_map_address);
    wr(8'h84, 8'h00, 0);
    chk(8'h00, 8'(na));
  endtask
  task automatic t_addr();
    for (int p = 0; p < 2; p++) begin
      addr_select_pin <= p[0];
      wb[0] = 8'h5a ^ 8'(p);
      wr(8'h42 - 8'(2 * p), 8'h10, 1);
      chk(8'h00, 8'(na));
      wr(8'h40 + 8'(2 * p), 8'h10, 1);
      chk(8'h03, 8'(na));
      rd(8'h40 + 8'(2 * p), 8'h10, 1);
      chk(8'h5a ^ 8'(p), rb[0]);
    end
  endtask
  task automatic t_incr();
    wb = '{8'h11, 8'h22, 8'h33, 8'h44};
    wr(8'h42, 8'h20, 4);
    chk(8'h06, 8'(na));
    rd(8'h42, 8'h20, 4);
    for (int i = 0; i < 4; i++)
      chk(wb[i], rb[i]);
  endtask
  // top two registers, one byte past the top, then a bad subaddress
  task automatic t_top();
    wb = '{8'h84, 8'h3c, 8'h99, 8'h00};
    wr(8'h42, 8'hfd, 3);
    chk(8'h04, 8'(na));
    chk(8'h84, postproc_map_address);
    rd(8'h42, 8'hfd, 4);
    chk(8'h84, rb[0]);
    for (int i = 1; i < 4; i++)
      chk(8'h3c, rb[i]);
    wr(8'h42, 8'hff, 1);
    chk(8'h01, 8'(na));
  endtask
  task automatic t_vpp();
    addr_select_pin <= 1'b0;
    wb[0] = 8'h20;
    wr(8'h40, 8'h0e, 1);
    wb[0] = 8'h6e;
    wr(8'h84, 8'h30, 1);
    chk(8'h03, 8'(na));
    rd(8'h84, 8'h30, 1);
    chk(8'h6e, rb[0]);
  endtask
  // fill 0x50 in each sub map, then read them back in turn
  task automatic t_submap();
    for (int s = 0; s < 6; s++) begin
      wb[0] = 8'(s % 3) << 5;
      wr(8'h40, 8'h0e, 1);
      chk(wb[0], submap_select);
      wb[0] = 8'hc0 + 8'(s % 3);
      if (s < 3) wr(8'h40, 8'h50, 1);
      else begin
        rd(8'h40, 8'h50, 1);
        chk(wb[0], rb[0]);
      end
    end
    // reserved select value falls back to the user sub map
    wb[0] = 8'h60;
    wr(8'h40, 8'h0e, 1);
    rd(8'h40, 8'h50, 1);
    chk(8'hc0, rb[0]);
    wb[0] = 8'h00;
    wr(8'h40, 8'h0e, 1);
  endtask
  // stop in mid byte must leave the register untouched
  task automatic t_abort();
    logic k;
    wb[0] = 8'h77;
    wr(8'h40, 8'h60, 1);
    serial_master_model_i.start();
    serial_master_model_i.xfer(8'h40, 1'b1, rb[1], k);
    serial_master_model_i.xfer(8'h60, 1'b1, rb[1], k);
    for (int i = 0; i < 4; i++)
      serial_master_model_i.bit_x(1'b0, k);
    serial_master_model_i.stop();
    rd(8'h40, 8'h60, 1);
    chk(8'h77, rb[0]);
    // a start in mid byte must drop the byte; a port that missed it would store the next address bits
    serial_master_model_i.start();
    serial_master_model_i.xfer(8'h40, 1'b1, rb[1], k);
    serial_master_model_i.xfer(8'h60, 1'b1, rb[1], k);
    for (int i = 0; i < 4; i++)
      serial_master_model_i.bit_x(1'b0, k);
    serial_master_model_i.start();
    serial_master_model_i.xfer(8'h41, 1'b1, rb[1], k);
    serial_master_model_i.xfer(8'hff, 1'b1, rb[0], k);
    serial_master_model_i.stop();
    chk(8'h77, rb[0]);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    addr_select_pin = 1'b0;
    num_errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    t_reset();
    t_addr();
    t_incr();
    t_top();
    t_vpp();
    t_submap();
    t_abort();
    complete_run();
  end
  // about four times what the tests need, well inside the cycle budget
  initial begin
    #1600000;
    num_errors++;
    complete_run();
  end
endmodule
bind i2c_register_map_port i2c_map_port_checker i2c_map_port_checker_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .serial_clock_pin(serial_clock_pin), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
  .serial_data_oe(serial_data_oe), .addr_select_pin(addr_select_pin), .submap_select(submap_select),
  .postproc_map_address(postproc_map_address));
